// ---- ssb_pin_if.sv ----
// Purpose: carries conditioned pin events from the synchroniser
// Assumes: single sys_clk domain on both ends
// Notes:   ack_pulse lasts one cycle
`timescale 1ns/1ps
`default_nettype none
interface ssb_pin_if;
    logic open_lvl;
    logic ack_pulse;
    modport src (output open_lvl, output ack_pulse);
    modport dst (input open_lvl, input ack_pulse);
endinterface : ssb_pin_if
`default_nettype wire

// ---- ssb_pin_sync.sv ----
// Purpose: three-stage synchronisers for the open-sensor and ack pins
// Assumes: pins are asynchronous to sys_clk
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ssb_pin_sync
    import ssb_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic sensor_open_pin,
    input  wire logic ack_key_pin,
    ssb_pin_if.src    pin
);
    typedef struct packed {
        logic [2:0] op;
        logic [2:0] ak;
        logic       open_lvl;
        logic       ack_lvl;
        logic       ack_pulse;
    } ssb_sync_s;

    ssb_sync_s s_r;
    ssb_sync_s s_nxt;

    always_comb
    begin
        s_nxt    = s_r;
        s_nxt.op = {s_r.op[1:0], sensor_open_pin};
        s_nxt.ak = {s_r.ak[1:0], ack_key_pin};
        if (s_r.op[1] == s_r.op[2])
            s_nxt.open_lvl = s_r.op[2];
        s_nxt.ack_pulse = 1'b0;
        if (s_r.ak[1] == s_r.ak[2])
        begin
            s_nxt.ack_lvl = s_r.ak[2];
            // R14: press becomes one event
            s_nxt.ack_pulse = s_r.ak[2] & ~s_r.ack_lvl;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign pin.open_lvl  = s_r.open_lvl;
    assign pin.ack_pulse = s_r.ack_pulse;

    property p_ack_single;
        @(posedge sys_clk) disable iff (!rst_b)
        s_r.ack_pulse |=> !s_r.ack_pulse;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack pulse longer than one cycle"); // R14
endmodule : ssb_pin_sync
`default_nettype wire

// ---- ssb_pkg.sv ----
// Purpose: shared constants and types of the sensor fault fallback block
// Assumes: 10 MHz sys_clk; outputs in 0.1 % steps, linear input in 0.01 mV
// Notes:   How it works list below
// How it works
// R1: response selector offers off, non-latching, latching
// R2: off mode drives upper limit, never alarms
// R3: non-latching drives fallback if in limits
// R4: fault flashes beacon, energises relay, ignores ack
// R5: non-latching alarm clears when fault ends
// R6: latching alarm stays until operator acknowledge
// R7: latching mode chooses output like non-latching
// R8: limit change clips stored fallback level
// R9: limits bounded by output type range
// R10: cool-only off mode drives zero output
// R11: remote value stale after 5 s faults
// R12: signed shift added, writable from level three
// R13: linear input 5 % beyond span faults
// R14: ack one-cycle event, fault sampled per tick
package ssb_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ    = 10_000_000;
    localparam int unsigned TICK_MS   = 100;
    localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned STALE_S   = 5;
    localparam int unsigned STALE_CYC = CLK_HZ * STALE_S;
    localparam int unsigned FLASH_MS  = 250;
    localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_UPPER  = 8'h04;
    localparam logic [7:0] A_LOWER  = 8'h08;
    localparam logic [7:0] A_FALLBK = 8'h0c;
    localparam logic [7:0] A_SHIFT  = 8'h10;
    localparam logic [7:0] A_LEVEL  = 8'h14;
    localparam logic [7:0] A_LINLO  = 8'h18;
    localparam logic [7:0] A_LINHI  = 8'h1c;
    localparam logic [7:0] A_REMOTE = 8'h20;
    localparam logic [7:0] A_STATUS = 8'h24;
    localparam logic [7:0] A_MASK   = 8'h28;
    localparam logic [7:0] A_STATE  = 8'h2c;
    localparam logic [7:0] A_VALUES = 8'h30;
    localparam int unsigned REMOTE_HOLD_ADDR = 203;
    // ctrl fields: [1:0] select, [3:2] output type, [4] linear, [5] remote
    localparam int CT_SEL = 0;
    localparam int CT_TYP = 2;
    localparam int CT_LIN = 4;
    localparam int CT_REM = 5;
    localparam logic [5:0] CTRL_RST = 6'h04;
    // status / mask bits
    localparam int EV_FAULT = 0;
    localparam int EV_CLEAR = 1;
    localparam int EV_ACK   = 2;
    // ==========================================================
    // values
    localparam logic signed [15:0] PCT_FULL  = 16'sh03e8;
    localparam logic signed [15:0] PCT_ZERO  = 16'sh0000;
    localparam logic signed [15:0] LINLO_RST = -16'sh03e8;
    localparam logic signed [15:0] LINHI_RST = 16'sh1f40;
    localparam logic signed [17:0] MARGIN_DIV = 18'sh00014;
    localparam logic [2:0] LEVEL_ADJ = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SSB_RSP_OFF, SSB_RSP_NONLATCH, SSB_RSP_LATCH} ssb_rsp_e;
    typedef enum logic [1:0] {SSB_OUT_HEATCOOL, SSB_OUT_HEAT, SSB_OUT_COOL} ssb_out_e;
endpackage : ssb_pkg

// ---- ssb_sensor_fallback.sv ----
// Purpose: process value path, sensor fault detection and fallback output
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   output values are signed tenths of a percent
`timescale 1ns/1ps
`default_nettype none
module ssb_sensor_fallback
    import ssb_pkg::*;
#(
    parameter int unsigned TICK_N  = TICK_CYC,
    parameter int unsigned STALE_N = STALE_CYC,
    parameter int unsigned FLASH_N = FLASH_CYC
)
(
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [7:0]         s_axi_awaddr,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    output logic [1:0]              s_axi_bresp,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    input  wire logic [7:0]         s_axi_araddr,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    input  wire logic signed [15:0] sensor_value,
    input  wire logic signed [15:0] demand,
    input  wire logic               sensor_open_pin,
    input  wire logic               ack_key_pin,
    output logic signed [15:0]      control_output,
    output logic signed [15:0]      process_value,
    output logic                    alarm_beacon,
    output logic                    alarm_relay,
    output logic                    irq
);
    import ssb_pkg::*;

    typedef struct packed {
        logic [5:0]         ctrl;
        logic signed [15:0] upper;
        logic signed [15:0] lower;
        logic signed [15:0] fallback;
        logic signed [15:0] shift;
        logic [2:0]         level;
        logic signed [15:0] lin_lo;
        logic signed [15:0] lin_hi;
        logic signed [15:0] remote_pv;
        logic [31:0]        tick_cnt;
        logic [31:0]        stale_cnt;
        logic [31:0]        flash_cnt;
        logic               flash;
        logic               fault;
        logic               alarm;
        logic               beacon;
        logic [2:0]         sts;
        logic [2:0]         mask;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [31:0]        rdata;
        logic signed [15:0] ctl_out;
        logic signed [15:0] pv;
    } ssb_main_s;

    ssb_main_s s_r;
    ssb_main_s s_nxt;

    ssb_pin_if pin ();

    ssb_pin_sync u_sync (
        .sys_clk         (sys_clk),
        .rst_b           (rst_b),
        .sensor_open_pin (sensor_open_pin),
        .ack_key_pin     (ack_key_pin),
        .pin             (pin)
    );

    // ==========================================================
    // helpers
    function automatic logic signed [15:0] clip(
        input logic signed [15:0] v,
        input logic signed [15:0] lo,
        input logic signed [15:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clip

    function automatic logic [32:0] view(input logic [7:0] a);
        unique case (a)
            A_CTRL:   view = {1'b1, 26'h0, s_r.ctrl};
            A_UPPER:  view = {1'b1, {16{s_r.upper[15]}}, s_r.upper};
            A_LOWER:  view = {1'b1, {16{s_r.lower[15]}}, s_r.lower};
            A_FALLBK: view = {1'b1, {16{s_r.fallback[15]}}, s_r.fallback};
            A_SHIFT:  view = {1'b1, {16{s_r.shift[15]}}, s_r.shift};
            A_LEVEL:  view = {1'b1, 29'h0, s_r.level};
            A_LINLO:  view = {1'b1, {16{s_r.lin_lo[15]}}, s_r.lin_lo};
            A_LINHI:  view = {1'b1, {16{s_r.lin_hi[15]}}, s_r.lin_hi};
            A_REMOTE: view = {1'b1, {16{s_r.remote_pv[15]}}, s_r.remote_pv};
            A_STATUS: view = {1'b1, 29'h0, s_r.sts};
            A_MASK:   view = {1'b1, 29'h0, s_r.mask};
            A_STATE:  view = {1'b1, 29'h0, stale, s_r.alarm, s_r.fault};
            A_VALUES: view = {1'b1, s_r.pv, s_r.ctl_out};
            default:  view = {1'b0, 32'h0};
        endcase
    endfunction : view

    // ==========================================================
    // combinational terms
    logic                wr_go;
    logic                rd_go;
    logic                tick;
    logic                stale;
    logic                lin_bad;
    logic                new_fault;
    logic                ack_clr;
    logic [32:0]         old_v;
    logic [32:0]         rd_v;
    logic [31:0]         wv;
    logic [2:0]          ev;
    logic [1:0]          sel;
    logic signed [15:0]  tmin;
    logic signed [15:0]  tmax;
    logic signed [15:0]  src;
    logic signed [17:0]  margin;

    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
    assign rd_go = s_axi_arvalid & ~s_r.rvalid;
    assign sel   = s_r.ctrl[CT_SEL +: 2];
    // R11: stale once the hold time has run out
    assign stale = s_r.ctrl[CT_REM] & (s_r.stale_cnt == 32'(STALE_N));

    always_comb
    begin
        s_nxt     = s_r;
        ev        = 3'h0;
        ack_clr   = 1'b0;
        tick      = (s_r.tick_cnt == 32'(TICK_N - 1));
        s_nxt.tick_cnt = tick ? 32'h0 : s_r.tick_cnt + 32'h1;
        // ======================================================
        // register writes
        old_v = view(s_axi_awaddr);
        rd_v  = view(s_axi_araddr);
        wv    = old_v[31:0];
        for (int i = 0; i < 4; i++)
        begin
            if (s_axi_wstrb[i])
                wv[8*i +: 8] = s_axi_wdata[8*i +: 8];
        end
        if (s_r.stale_cnt != 32'(STALE_N))
            s_nxt.stale_cnt = s_r.stale_cnt + 32'h1;
        if (s_r.bvalid && s_axi_bready)
            s_nxt.bvalid = 1'b0;
        if (wr_go)
        begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = old_v[32] ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_awaddr)
                A_CTRL:
                begin
                    s_nxt.ctrl[5:2] = wv[5:2];
                    // R1: only the three settings are stored
                    if (wv[1:0] != 2'h3)
                        s_nxt.ctrl[1:0] = wv[1:0];
                    if (wv[3:2] == 2'h3)
                        s_nxt.ctrl[3:2] = s_r.ctrl[3:2];
                end
                A_UPPER:  s_nxt.upper = wv[15:0];
                A_LOWER:  s_nxt.lower = wv[15:0];
                A_FALLBK: s_nxt.fallback = wv[15:0];
                // R12: shift locked below level three
                A_SHIFT:
                begin
                    if (s_r.level >= LEVEL_ADJ)
                        s_nxt.shift = wv[15:0];
                end
                A_LEVEL:  s_nxt.level = wv[2:0];
                A_LINLO:  s_nxt.lin_lo = wv[15:0];
                A_LINHI:  s_nxt.lin_hi = wv[15:0];
                // R11: each write restarts the hold time
                A_REMOTE:
                begin
                    s_nxt.remote_pv = wv[15:0];
                    s_nxt.stale_cnt = 32'h0;
                end
                A_STATUS: s_nxt.sts = s_r.sts & ~s_axi_wdata[2:0];
                A_MASK:   s_nxt.mask = wv[2:0];
                default:  s_nxt.bresp = RESP_SLVERR;
            endcase
        end
        // ======================================================
        // output limits
        tmin = (s_nxt.ctrl[CT_TYP +: 2] == SSB_OUT_HEAT) ? PCT_ZERO : -PCT_FULL;
        tmax = (s_nxt.ctrl[CT_TYP +: 2] == SSB_OUT_COOL) ? PCT_ZERO : PCT_FULL;
        // R9: limits kept inside the type range
        s_nxt.upper = clip(s_nxt.upper, tmin, tmax);
        s_nxt.lower = clip(s_nxt.lower, tmin, s_nxt.upper);
        // R8: fallback pulled to the violated limit
        s_nxt.fallback = clip(s_nxt.fallback, s_nxt.lower, s_nxt.upper);
        // ======================================================
        // register reads
        if (s_r.rvalid && s_axi_rready)
            s_nxt.rvalid = 1'b0;
        if (rd_go)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata  = rd_v[31:0];
            s_nxt.rresp  = rd_v[32] ? RESP_OKAY : RESP_SLVERR;
        end
        // ======================================================
        // fault detection, once per tick
        margin  = (18'(s_r.lin_hi) - 18'(s_r.lin_lo)) / MARGIN_DIV;
        // R13: linear input beyond span plus margin
        lin_bad = s_r.ctrl[CT_LIN]
                  & ((18'(sensor_value) > 18'(s_r.lin_hi) + margin)
                  | (18'(sensor_value) < 18'(s_r.lin_lo) - margin));
        new_fault = pin.open_lvl | lin_bad | stale;
        src       = s_r.ctrl[CT_REM] ? s_r.remote_pv : sensor_value;
        // R14: fault and value sampled on the tick
        if (tick)
        begin
            s_nxt.fault = new_fault;
            // R12: shift applied to every value; wraps on overflow
            s_nxt.pv    = 16'(src + s_r.shift);
            ev[EV_FAULT] = new_fault & ~s_r.fault;
            ev[EV_CLEAR] = ~new_fault & s_r.fault;
        end
        // ======================================================
        // alarm
        unique case (sel)
            // R2: no alarm in off mode
            SSB_RSP_OFF: s_nxt.alarm = 1'b0;
            // R5: follows the fault directly
            SSB_RSP_NONLATCH: s_nxt.alarm = s_r.fault;
            SSB_RSP_LATCH:
            begin
                // R4: ack ignored while fault stands
                if (s_r.fault)
                    s_nxt.alarm = 1'b1;
                // R6: cleared only by acknowledge
                else if (pin.ack_pulse && s_r.alarm)
                begin
                    s_nxt.alarm = 1'b0;
                    ack_clr     = 1'b1;
                end
            end
            default: s_nxt.alarm = 1'b0;
        endcase
        ev[EV_ACK] = ack_clr;
        if (!s_nxt.alarm || s_r.flash_cnt == 32'(FLASH_N - 1))
            s_nxt.flash_cnt = 32'h0;
        else
            s_nxt.flash_cnt = s_r.flash_cnt + 32'h1;
        if (!s_nxt.alarm)
            s_nxt.flash = 1'b1;
        else if (s_r.flash_cnt == 32'(FLASH_N - 1))
            s_nxt.flash = ~s_r.flash;
        // R4: beacon flashes while alarm stands
        s_nxt.beacon = s_nxt.alarm & s_nxt.flash;
        // set wins over a clear in the same cycle
        s_nxt.sts = s_nxt.sts | ev;
        // ======================================================
        // control output
        if (!s_r.fault)
            s_nxt.ctl_out = clip(demand, s_r.lower, s_r.upper);
        else if (sel == SSB_RSP_OFF || sel == 2'h3)
        begin
            // R10: cool-only output held at zero
            if (s_r.ctrl[CT_TYP +: 2] == SSB_OUT_COOL)
                s_nxt.ctl_out = PCT_ZERO;
            // R2: upper limit, fallback ignored
            else
                s_nxt.ctl_out = s_r.upper;
        end
        // R3: fallback if inside the limits
        // R7: latching uses the same choice
        else if (s_r.fallback >= s_r.lower && s_r.fallback <= s_r.upper)
            s_nxt.ctl_out = s_r.fallback;
        else
            s_nxt.ctl_out = s_r.upper;
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r          <= '0;
            s_r.ctrl     <= CTRL_RST;
            s_r.upper    <= PCT_FULL;
            s_r.lin_lo   <= LINLO_RST;
            s_r.lin_hi   <= LINHI_RST;
            s_r.flash    <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready  = wr_go;
    assign s_axi_wready   = wr_go;
    assign s_axi_bvalid   = s_r.bvalid;
    assign s_axi_bresp    = s_r.bresp;
    assign s_axi_arready  = rd_go;
    assign s_axi_rvalid   = s_r.rvalid;
    assign s_axi_rdata    = s_r.rdata;
    assign s_axi_rresp    = s_r.rresp;
    assign control_output = s_r.ctl_out;
    assign process_value  = s_r.pv;
    assign alarm_beacon   = s_r.beacon;
    assign alarm_relay    = s_r.alarm;
    assign irq            = |(s_r.sts & s_r.mask);

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_sel_legal;
        sel != 2'h3;
    endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("illegal response setting"); // R1

    property p_off_upper;
        s_r.fault && sel == SSB_RSP_OFF && s_r.ctrl[3:2] != SSB_OUT_COOL
        |=> s_r.ctl_out == $past(s_r.upper) && !s_r.alarm;
    endproperty
    a_off_upper: assert property (p_off_upper) else $error("off mode output wrong"); // R2

    property p_fallback_used;
        s_r.fault && (sel == SSB_RSP_NONLATCH || sel == SSB_RSP_LATCH)
        |=> s_r.ctl_out == $past(s_r.fallback);
    endproperty
    a_fallback_used: assert property (p_fallback_used) else $error("fallback not driven"); // R3

    property p_fault_alarm;
        s_r.fault && sel != SSB_RSP_OFF |=> s_r.alarm ##1 s_r.alarm || !s_r.fault;
    endproperty
    a_fault_alarm: assert property (p_fault_alarm) else $error("no alarm on fault"); // R4

    property p_nonlatch_clear;
        $fell(s_r.fault) && sel == SSB_RSP_NONLATCH && $stable(sel) |=> !s_r.alarm;
    endproperty
    a_nonlatch_clear: assert property (p_nonlatch_clear) else $error("alarm not cleared"); // R5

    property p_latch_hold;
        s_r.alarm && sel == SSB_RSP_LATCH && !pin.ack_pulse |=> s_r.alarm;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched alarm dropped"); // R6

    property p_clip;
        s_r.lower <= s_r.fallback && s_r.fallback <= s_r.upper;
    endproperty
    a_clip: assert property (p_clip) else $error("fallback outside limits"); // R8

    property p_range;
        s_r.upper <= PCT_FULL && s_r.lower >= -PCT_FULL && s_r.lower <= s_r.upper;
    endproperty
    a_range: assert property (p_range) else $error("limit out of range"); // R9

    property p_cool_zero;
        s_r.fault && sel == SSB_RSP_OFF && s_r.ctrl[3:2] == SSB_OUT_COOL
        |=> s_r.ctl_out == PCT_ZERO;
    endproperty
    a_cool_zero: assert property (p_cool_zero) else $error("cool output not zero"); // R10

    property p_stale;
        tick && stale |=> s_r.fault;
    endproperty
    a_stale: assert property (p_stale) else $error("stale value not faulted"); // R11

    property p_shift;
        tick |=> s_r.pv == 16'($past(src) + $past(s_r.shift));
    endproperty
    a_shift: assert property (p_shift) else $error("shift not applied"); // R12

    property p_lin;
        tick && lin_bad |=> s_r.fault;
    endproperty
    a_lin: assert property (p_lin) else $error("linear overrange missed"); // R13

    property p_fault_tick;
        !tick |=> $stable(s_r.fault);
    endproperty
    a_fault_tick: assert property (p_fault_tick) else $error("fault moved off tick"); // R14

    c_latch_ack: cover property (ack_clr);
    c_stale: cover property (tick && stale);
    c_nonlatch: cover property ($fell(s_r.alarm) && sel == SSB_RSP_NONLATCH);
    c_irq: cover property ($rose(irq));
endmodule : ssb_sensor_fallback
`default_nettype wire

// ---- ssb_sensor_fallback_test.sv ----
// Purpose: self-checking bench of the fallback block
// Assumes: short TICK_N, STALE_N, FLASH_N
// Notes:   waits of two ticks plus 8 cycles cover sync plus tick latency
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module ssb_sensor_fallback_test;
    import ssb_pkg::*;
    localparam int TK = 20;
    logic sys_clk, rst_b, aw, w, b, ar, r, op, ak, rl, bc, iq;
    logic awr, wr_r, bv, arr, rv;
    logic [7:0] aa, ra;
    logic [31:0] wd, rd_d;
    logic [1:0] br, rr, bs;
    logic [3:0] ws;
    logic [4:0] nb;
    logic signed [15:0] sv, dem, co, pv;
    int n_errors, cmp_count, n;
    logic [31:0] x, got;
    logic [1:0] rs;
    ssb_sensor_fallback #(.TICK_N(TK), .STALE_N(200), .FLASH_N(8)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awvalid(aw), .s_axi_awready(awr),
        .s_axi_awaddr(aa), .s_axi_wvalid(w), .s_axi_wready(wr_r), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(b), .s_axi_bresp(br),
        .s_axi_arvalid(ar), .s_axi_arready(arr), .s_axi_araddr(ra), .s_axi_rvalid(rv),
        .s_axi_rready(r), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .sensor_value(sv),
        .demand(dem), .sensor_open_pin(op), .ack_key_pin(ak), .control_output(co),
        .process_value(pv), .alarm_beacon(bc), .alarm_relay(rl), .irq(iq));
    ssb_sensor_model u_sen (.sys_clk(sys_clk), .sensor_open_pin(op), .ack_key_pin(ak),
        .sensor_value(sv));
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // ==========================================================
    // bus master: ready sampled just before the taking edge
    task automatic hs(input int k);
        logic ok;
        n = 0;
        do
        begin
            @(negedge sys_clk);
            ok = (k == 0) ? (awr && wr_r) : (k == 1) ? bv : (k == 2) ? arr : rv;
            @(posedge sys_clk);
            n++;
        end while (!ok && n < 100);
        if (!ok)
        begin
            n_errors++;
            final_report();
        end
    endtask : hs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        aw <= 1'b1; w <= 1'b1; aa <= a; wd <= d;
        hs(0);
        aw <= 1'b0; w <= 1'b0; b <= 1'b1;
        hs(1);
        bs = br; b <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ar <= 1'b1; ra <= a;
        hs(2);
        ar <= 1'b0; r <= 1'b1;
        hs(3);
        got = rd_d; rs = rr; r <= 1'b0;
    endtask : rd
    task automatic settle();
        repeat (2 * TK + 8) @(posedge sys_clk);
    endtask : settle
    // ==========================================================
    // main sequence; DUT holds limits 0..1000, fallback 300
    initial
    begin
        n_errors = 0; cmp_count = 0; x = 32'hfba3;
        rst_b = 1'b0; aw = 0; w = 0; b = 0; ar = 0; r = 0; aa = 0; ra = 0; wd = 0;
        dem = 16'sh0000; ws = 4'hf;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(A_UPPER);
        `CHK(got, 32'h0000_03e8) // upper reset
        rd(8'hfc);
        `CHK(rs, RESP_SLVERR) // unmapped
        wr(8'hfc, 32'h0);
        `CHK(bs, RESP_SLVERR) // unmapped write
        wr(A_MASK, 32'h1); wr(A_FALLBK, 32'd300);
        for (int m = 0; m < 3; m++)
        begin
            x = xs(x);
            dem <= 16'(x % 1001);
            wr(A_CTRL, 32'(m) | 32'h4);
            settle();
            `CHK(co, dem) // demand path
            u_sen.set_open(1'b1);
            settle();
            `CHK(co, (m == 0) ? 16'sh03e8 : 16'sh012c)
            `CHK(rl, m != 0) // relay
            nb = 5'd0;
            repeat (16)
            begin
                @(posedge sys_clk);
                nb = nb + 5'(bc);
            end
            `CHK(nb, (m != 0) ? 5'd8 : 5'd0) // beacon flashes
            `CHK(iq, 1'b1) // fault event
            wr(A_STATUS, 32'h7);
            `CHK(iq, 1'b0) // cleared
            u_sen.press();
            `CHK(rl, m != 0) // ack ignored
            u_sen.set_open(1'b0);
            settle();
            `CHK(rl, m == 2) // after fault
            u_sen.press();
            `CHK(rl, 1'b0) // ack clears
            $display("mode %0d done", m);
        end
        wr(A_UPPER, 32'd200); rd(A_FALLBK);
        `CHK(got, 32'd200) // clip fallback
        wr(A_CTRL, 32'h8); wr(A_UPPER, 32'hffff_ff9c); u_sen.set_open(1'b1);
        settle();
        `CHK(co, 16'sh0000) // cool off
        u_sen.set_open(1'b0);
        wr(A_SHIFT, 32'h77); wr(A_LEVEL, 32'h3);
        ws <= 4'h1;
        wr(A_SHIFT, 32'hffff_ff05);
        ws <= 4'hf;
        `CHK(bs, RESP_OKAY) // shift write taken
        settle();
        `CHK(pv, 16'sh0105) // shift added
        wr(A_CTRL, 32'h15); u_sen.set_value(16'sd8450);
        settle();
        `CHK(rl, 1'b0) // edge of margin
        u_sen.set_value(16'sd8451);
        settle();
        `CHK(rl, 1'b1) // beyond margin
        wr(A_CTRL, 32'h25); wr(A_REMOTE, 32'h40);
        settle();
        `CHK(rl, 1'b0) // fresh remote value
        `CHK(pv, 16'sh0045) // shift on remote
        repeat (200) @(posedge sys_clk);
        `CHK(rl, 1'b1) // stale value faults
        $display("limits, shift, linear and stale done");
        final_report();
    end
endmodule : ssb_sensor_fallback_test
`default_nettype wire

// ---- ssb_sensor_model.sv ----
// Purpose: far-side sensor and operator key model
// Assumes: pins change just after sys_clk edges
// Notes:   key held 6 cycles so the 3-stage sync sees it
`timescale 1ns/1ps
`default_nettype none
module ssb_sensor_model (
    input  wire logic          sys_clk,
    output logic               sensor_open_pin,
    output logic               ack_key_pin,
    output logic signed [15:0] sensor_value
);
    // ==========================================================
    // far side
    initial
    begin
        sensor_open_pin = 1'b0;
        ack_key_pin     = 1'b0;
        sensor_value    = 16'sh0100;
    end
    task automatic set_open(input logic v);
        @(posedge sys_clk);
        sensor_open_pin <= v;
    endtask : set_open
    task automatic set_value(input logic signed [15:0] v);
        @(posedge sys_clk);
        sensor_value <= v;
    endtask : set_value
    task automatic press();
        @(posedge sys_clk);
        ack_key_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        ack_key_pin <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : press
endmodule : ssb_sensor_model
`default_nettype wire
